// ==== hw/scr_pkg.sv ====
// Constants for the set/clear/toggle register bank.
// Assumes a simple synchronous register port driven by the peripheral bus logic.
package scr_pkg;
  // Word offsets within the bank's own port: base, set, clear and toggle views.
  localparam logic [1:0] ADDR_BASE = 2'h0;
  localparam logic [1:0] ADDR_SET = 2'h1;
  localparam logic [1:0] ADDR_CLEAR = 2'h2;
  localparam logic [1:0] ADDR_TOGGLE = 2'h3;
  // Default width and bit access layout of the shared content.
  localparam int DATA_WIDTH = 8;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] RW_MASK = 8'h0f;
  localparam logic [7:0] RO_MASK = 8'h30;
  localparam logic [7:0] WO_MASK = 8'h40;
  // Value returned on write-only bits, which software must not rely on.
  localparam logic [7:0] WO_READ_VALUE = 8'h00;
endpackage

// ==== hw/scr_register_pair.sv ====
// Register bank with a base register and its set, clear and toggle aliases.
// Assumes one synchronous register port; the surrounding bus decodes the bank select.
`timescale 1ns/10ps
// Overview of operation
// - Read/write bits store and return writes.
// - Read-only bits ignore software writes.
// - Write-only bits read as undefined value.
// - Reserved bits always read as zero.
// - Reset values restored; debug bits spared softly.
// - Base and aliases read identical contents.
// - Clear alias ones force bits zero.
// - Set alias ones force bits one.
// - Toggle alias ones invert bits.
// - Alias writes change bits in one write.
module scr_register_pair #(
  parameter int WIDTH = scr_pkg::DATA_WIDTH,
  parameter logic [WIDTH-1:0] RESET_VALUE = WIDTH'(scr_pkg::RESET_VALUE),
  parameter logic [WIDTH-1:0] RW_MASK = WIDTH'(scr_pkg::RW_MASK),
  parameter logic [WIDTH-1:0] RO_MASK = WIDTH'(scr_pkg::RO_MASK),
  parameter logic [WIDTH-1:0] WO_MASK = WIDTH'(scr_pkg::WO_MASK),
  parameter bit DEBUG_CONTROL = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic softReset,
  input wire logic writeEnable,
  input wire logic [1:0] address,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [WIDTH-1:0] hwValue,
  output logic [WIDTH-1:0] readData,
  output logic [WIDTH-1:0] content
);

  ////////////////////////////////////////////////////////////////////////////
  // Bit layout and timing.

  // The pair is one shared word that software sees through four views: the base
  // view and the set, clear and toggle aliases. Each bit belongs to one access
  // class, chosen by the three mask parameters; a bit in none of them is reserved.

  // Read/write and write-only bits live in flip-flops. Read-only bits are not
  // stored at all; they show the hardware value, so no software write reaches
  // them. Reserved bits are neither stored nor shown.

  // A write is taken at the rising edge on which the strobe is high. The content
  // output changes at that same edge and the read data one edge later, so a read
  // right after a write sees the old word for one cycle.

  // Writes may arrive on every cycle. Each alias acts only on the positions
  // written as one, which lets software change single bits in one bus write
  // while other code owns the neighbouring bits.

  // Both resets restore the reset value parameter. The software reset is ignored
  // when the instance holds debug control state, which must survive it.

  // The read data does not depend on the address, so a read of any view costs
  // the same and shows the same word; there is no separate read strobe.

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  // Refuse layouts that the logic cannot serve; unlisted bits are reserved.
  if (WIDTH < 1 || WIDTH > 32)
  begin
    $error("Register width out of range.");
  end
  if ((RW_MASK & RO_MASK) != '0 || (RW_MASK & WO_MASK) != '0)
  begin
    $error("Read/write bits overlap another access class.");
  end
  if ((RO_MASK & WO_MASK) != '0)
  begin
    $error("Read-only and write-only bits overlap.");
  end

  // Bits that a software write may reach, and bits that carry any meaning.
  localparam logic [WIDTH-1:0] WRITE_MASK = RW_MASK | WO_MASK;
  localparam logic [WIDTH-1:0] USED_MASK = RW_MASK | RO_MASK | WO_MASK;
  // Filler shown on write-only bits; software must not rely on it.
  localparam logic [WIDTH-1:0] WO_READ = WIDTH'(scr_pkg::WO_READ_VALUE);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Keeps only the bits that a software write may reach; read-only and reserved
  // positions are dropped here, so no view can ever store them.
  function automatic logic [WIDTH-1:0] writable_bits(input logic [WIDTH-1:0] data);
    writable_bits = data & WRITE_MASK;
  endfunction

  // True when a taken write addresses the given view of the pair.
  function automatic logic view_hit(input logic strobe, input logic [1:0] addr,
    input logic [1:0] code);
    view_hit = strobe && (addr == code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes.

  logic baseWrite;
  logic setWrite;
  logic clearWrite;
  logic toggleWrite;

  // One strobe per view; at most one is high, since the address picks one view.
  assign baseWrite = view_hit(writeEnable, address, scr_pkg::ADDR_BASE);
  assign setWrite = view_hit(writeEnable, address, scr_pkg::ADDR_SET);
  assign clearWrite = view_hit(writeEnable, address, scr_pkg::ADDR_CLEAR);
  assign toggleWrite = view_hit(writeEnable, address, scr_pkg::ADDR_TOGGLE);

  ////////////////////////////////////////////////////////////////////////////
  // Write path.

  logic [WIDTH-1:0] stored;
  logic [WIDTH-1:0] next_stored;

  // Compute the new software-writable content for an access to any view.
  always_comb
  begin
    next_stored = stored;
    if (baseWrite)
    begin
      next_stored = (stored & ~WRITE_MASK) | writable_bits(writeData);
    end
    else if (setWrite)
    begin
      next_stored = stored | writable_bits(writeData);
    end
    else if (clearWrite)
    begin
      next_stored = stored & ~writable_bits(writeData);
    end
    else if (toggleWrite)
    begin
      next_stored = stored ^ writable_bits(writeData);
    end
  end

  // Holds the writable bits; soft reset spares debug control banks.
  always_ff @(posedge clock)
  begin
    if (rst || (softReset && !DEBUG_CONTROL))
      stored <= RESET_VALUE & WRITE_MASK;
    else
      stored <= next_stored;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  wire logic [WIDTH-1:0] view;

  // Each bit picks its read source by its access class.
  for (genvar b = 0; b < WIDTH; b++)
  begin : g_view_bit
    if (RW_MASK[b])
    begin
      assign view[b] = stored[b];
    end
    else if (RO_MASK[b])
    begin
      assign view[b] = hwValue[b];
    end
    else if (WO_MASK[b])
    begin
      assign view[b] = WO_READ[b];
    end
    else
    begin
      assign view[b] = 1'b0;
    end
  end

  // Every view returns the same contents, registered.
  always_ff @(posedge clock)
  begin
    if (rst)
      readData <= '0;
    else
      readData <= view & USED_MASK;
  end

  // Live content drives the block's own logic, including write-only bits.
  assign content = stored & WRITE_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_set;
    @(posedge clock) disable iff (rst || softReset)
    writeEnable && address == scr_pkg::ADDR_SET |=>
      (content & ($past(writeData) & WRITE_MASK)) == ($past(writeData) & WRITE_MASK);
  endproperty
  a_set: assert property (p_set) else $error("Set alias failed.");

  property p_clear;
    @(posedge clock) disable iff (rst || softReset)
    writeEnable && address == scr_pkg::ADDR_CLEAR |=> (content & $past(writeData)) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("Clear alias failed.");

  property p_toggle;
    @(posedge clock) disable iff (rst || softReset)
    writeEnable && address == scr_pkg::ADDR_TOGGLE |=>
      content == ($past(content) ^ ($past(writeData) & WRITE_MASK));
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle alias failed.");

  property p_keep;
    @(posedge clock) disable iff (rst || softReset)
    writeEnable && address != scr_pkg::ADDR_BASE |=>
      ((content ^ $past(content)) & ~$past(writeData)) == '0;
  endproperty
  a_keep: assert property (p_keep) else $error("Alias changed unselected bits.");

  property p_base;
    @(posedge clock) disable iff (rst || softReset)
    writeEnable && address == scr_pkg::ADDR_BASE |=>
      content == ($past(writeData) & WRITE_MASK);
  endproperty
  a_base: assert property (p_base) else $error("Base write not stored.");

  property p_reserved;
    @(posedge clock) disable iff (rst) (readData & ~USED_MASK) == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit read nonzero.");

  property p_readonly;
    @(posedge clock) disable iff (rst)
    (readData & RO_MASK) == ($past(hwValue) & RO_MASK) || $past(rst);
  endproperty
  a_readonly: assert property (p_readonly) else $error("Read-only bit wrong.");

  property p_reset;
    @(posedge clock) rst |=> content == (RESET_VALUE & WRITE_MASK) ##1 1;
  endproperty
  a_reset: assert property (p_reset) else $error("Reset value not restored.");

  // The set alias leaves every other bit exactly as it was.
  property p_set_exact;
    @(posedge clock) disable iff (rst || softReset)
    writeEnable && address == scr_pkg::ADDR_SET |=>
      content == ($past(content) | ($past(writeData) & WRITE_MASK));
  endproperty
  a_set_exact: assert property (p_set_exact) else $error("Set alias overreach.");

  // The clear alias leaves every other bit exactly as it was.
  property p_clear_exact;
    @(posedge clock) disable iff (rst || softReset)
    writeEnable && address == scr_pkg::ADDR_CLEAR |=>
      content == ($past(content) & ~($past(writeData) & WRITE_MASK));
  endproperty
  a_clear_exact: assert property (p_clear_exact) else $error("Clear alias overreach.");

  // Without a write or a reset the content stands still.
  property p_hold;
    @(posedge clock) disable iff (rst || softReset)
    !writeEnable |=> $stable(content);
  endproperty
  a_hold: assert property (p_hold) else $error("Content changed without a write.");

  // Every view reads the stored read/write bits of the previous cycle.
  property p_readback;
    @(posedge clock) disable iff (rst)
    !$past(rst) |-> (readData & RW_MASK) == ($past(content) & RW_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("Read data lost the content.");

  // A software reset restores the reset value unless debug state is held.
  property p_softreset;
    @(posedge clock) disable iff (rst)
    softReset && !DEBUG_CONTROL |=> content == (RESET_VALUE & WRITE_MASK);
  endproperty
  a_softreset: assert property (p_softreset) else $error("Soft reset missed.");

  // Write-only bits show the filler, never what was stored.
  property p_wo_filler;
    @(posedge clock) disable iff (rst)
    !$past(rst) |-> (readData & WO_MASK) == (WO_READ & WO_MASK);
  endproperty
  a_wo_filler: assert property (p_wo_filler) else $error("Write-only bits leaked.");

  // The view decoder raises at most one strobe.
  property p_one_strobe;
    @(posedge clock) disable iff (rst)
    $onehot0({baseWrite, setWrite, clearWrite, toggleWrite});
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("Two views written at once.");

  // Reset clears the read data as well.
  property p_reset_read;
    @(posedge clock) rst |=> readData == '0;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("Read data not cleared.");

endmodule

// ==== verification/scr_register_pair_tb.sv ====
// Self-checking bench for the set/clear/toggle register bank.
// Assumes the package default masks and a 100 MHz clock.
`timescale 1ns/10ps
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic softReset = 1'b0;
  logic writeEnable = 1'b0;
  logic [1:0] address = 2'h0;
  logic [7:0] writeData = 8'h00;
  logic [7:0] hwValue = 8'h20;
  logic [7:0] readData;
  logic [7:0] content;
  logic [7:0] model = 8'h00;
  logic [7:0] wmask = scr_pkg::RW_MASK | scr_pkg::WO_MASK;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // The block under test with its default layout.
  scr_register_pair scr_register_pair_i (.clock(clock), .rst(rst), .softReset(softReset),
    .writeEnable(writeEnable), .address(address), .writeData(writeData),
    .hwValue(hwValue), .readData(readData), .content(content));
  // Clock of 10 ns period.
  initial
  begin
    forever #5 clock = ~clock;
  end
  // Cycle ceiling that cuts a hang short.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch.
  task compare(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want)
    begin
      failures++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // One write; the content must change at the taking edge.
  task write(input logic [1:0] a, input logic [7:0] d);
    writeEnable = 1'b1;
    address = a;
    writeData = d;
    case (a)
      2'h0: model = d;
      2'h1: model = model | d;
      2'h2: model = model & ~d;
      default: model = model ^ d;
    endcase
    @(posedge clock);
    #1;
    compare(content, model & wmask);
  endtask
  // Idle cycle on a view; read data shows stored, read-only and zero reserved bits.
  task idle(input logic [1:0] a);
    writeEnable = 1'b0;
    address = a;
    @(posedge clock);
    #1;
    compare(readData, (model & scr_pkg::RW_MASK) | (hwValue & scr_pkg::RO_MASK));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Reset leaves the reset value in content and in the read view.
  task test_reset();
    compare(content, scr_pkg::RESET_VALUE & wmask);
    idle(2'h0);
    $display("reset test done");
  endtask
  // Base writes store writable bits; read-only and reserved bits ignore them.
  task test_base();
    write(2'h0, 8'hff);
    idle(2'h0);
    write(2'h0, 8'h05);
    idle(2'h0);
    $display("base test done");
  endtask
  // Alias writes act on the ones only; every view reads the same.
  task test_alias();
    write(2'h1, 8'h4a);
    write(2'h2, 8'h03);
    write(2'h3, 8'h0c);
    write(2'h3, 8'h41);
    for (int a = 0; a < 4; a++)
      idle(2'(a));
    $display("alias test done");
  endtask
  // Read-only bits follow the hardware value and refuse set writes.
  task test_readonly();
    hwValue = 8'h10;
    write(2'h1, 8'h30);
    idle(2'h1);
    $display("read-only test done");
  endtask
  // A software reset restores the reset value from a written content of 4f.
  task test_soft_reset();
    write(2'h0, 8'h4f);
    writeEnable = 1'b0;
    softReset = 1'b1;
    model = scr_pkg::RESET_VALUE;
    @(posedge clock);
    #1;
    softReset = 1'b0;
    compare(content, scr_pkg::RESET_VALUE & wmask);
    idle(2'h0);
    $display("soft reset test done");
  endtask
  // Main sequence of scenarios.
  initial
  begin
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    test_reset();
    test_base();
    test_alias();
    test_readonly();
    test_soft_reset();
    final_report();
  end
endmodule
